/* File: core/panel_sync_timing_generator.v */
// Summary of operation
// - The component count only wraps an internal counter; every active panel clock takes a new pixel.
// - Line syncs repeat every line total panel clocks, blanking included.
// - Line sync width is set in half base-clock steps.
// - Leading horizontal blank panel clocks precede each line's first active data.
// - Trailing blank equals line total minus leading blank minus active width.
// - Frame syncs repeat every frame total lines, blank lines included.
// - Frame sync width is set in half base-clock steps.
// - Leading blank lines precede the first active line of each frame.
// - Trailing blank lines equal frame total minus leading blank minus active lines.
// - Panel clock edges sit at an offset from their start, in half steps.
// - Frame sync edges sit at an offset from their start, in half steps.
// - Line sync edges sit at an offset from their start, in half steps.
// - Data valid edges sit at an offset from the data start, in half steps.
// - Panel clock period is set in sixteenths of a base clock.
// - Fractional ratio alternates floor and floor plus one periods, averaging exact.
// - Panel clock and data valid share the period counter; line and frame syncs each have their own counter.
// - Control edges are placed on a half base-clock grid.
// - Luma/chroma mode embeds start and end codes, blanking carries blank video only.
// - Panel clock may be inverted; syncs and data valid may be active low.
// - Each control waveform starts from its own local event.
// - Control outputs can be steered among the pins; data bit order can be reversed.
//
// The register offsets and the address-and-strobe port were left to the implementer.
`include "panel_timing_consts.vh"
`default_nettype none

module panel_sync_timing_generator (
  // Clock and reset
  input wire i_clock,
  input wire i_rst,
  // Register port
  input wire [4:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [15:0] o_rdata,
  // Pixel source
  input wire [7:0] i_video_data,
  output reg o_data_req,
  // Panel pins, two half-cycle phases each: bit 0 first half, bit 1 second; then the video byte
  output reg [1:0] o_pin0,
  output reg [1:0] o_pin1,
  output reg [1:0] o_pin2,
  output reg [1:0] o_pin3,
  output reg [7:0] o_video_data
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Half-step window test shared by every control counter
  function in_window;
    input [16:0] pos;
    input [15:0] off;
    input [15:0] width;
    begin
      in_window = (pos >= {1'b0, off}) && (pos < ({1'b0, off} + {1'b0, width}));
    end
  endfunction

  // Reference code byte: fixed field bit, vertical, horizontal and protection bits
  function [7:0] ref_code;
    input vblank;
    input eav;
    begin
      ref_code = {1'b1, 1'b0, vblank, eav, vblank ^ eav, eav, vblank, vblank ^ eav};
    end
  endfunction

  function [1:0] pick;
    input [1:0] sel;
    input [7:0] ctrls;
    begin
      case (sel)
        `SEL_PANEL_CLOCK: pick = ctrls[1:0];
        `SEL_LINE_SYNC: pick = ctrls[3:2];
        `SEL_FRAME_SYNC: pick = ctrls[5:4];
        default: pick = ctrls[7:6];
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg [`CTL_WIDTH-1:0] control;
  reg [3:0] components;
  reg [11:0] divisor;
  reg [11:0] line_total;
  reg [11:0] line_lead;
  reg [11:0] line_active;
  reg [15:0] line_sync_width;
  reg [15:0] line_sync_offset;
  reg [11:0] frame_total;
  reg [11:0] frame_lead;
  reg [11:0] frame_active;
  reg [15:0] frame_sync_width;
  reg [15:0] frame_sync_offset;
  reg [15:0] clock_offset;
  reg [15:0] valid_offset;
  reg [7:0] pin_map;

  reg [11:0] h_pos;
  reg [11:0] v_pos;

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      control <= `RST_CONTROL;
      components <= `RST_COMPONENTS;
      divisor <= `RST_DIVISOR;
      line_total <= 12'h000;
      line_lead <= 12'h000;
      line_active <= 12'h000;
      line_sync_width <= 16'h0000;
      line_sync_offset <= 16'h0000;
      frame_total <= 12'h000;
      frame_lead <= 12'h000;
      frame_active <= 12'h000;
      frame_sync_width <= 16'h0000;
      frame_sync_offset <= 16'h0000;
      clock_offset <= 16'h0000;
      valid_offset <= 16'h0000;
      pin_map <= `RST_PIN_MAP;
    end else if (i_wr) begin
      case (i_addr)
        `REG_CONTROL: control <= i_wdata[`CTL_WIDTH-1:0];
        `REG_COMPONENTS: components <= i_wdata[3:0];
        `REG_CLOCK_DIVISOR: divisor <= i_wdata[11:0];
        `REG_LINE_TOTAL: line_total <= i_wdata[11:0];
        `REG_LINE_LEAD: line_lead <= i_wdata[11:0];
        `REG_LINE_ACTIVE: line_active <= i_wdata[11:0];
        `REG_LINE_SYNC_WIDTH: line_sync_width <= i_wdata;
        `REG_LINE_SYNC_OFFSET: line_sync_offset <= i_wdata;
        `REG_FRAME_TOTAL: frame_total <= i_wdata[11:0];
        `REG_FRAME_LEAD: frame_lead <= i_wdata[11:0];
        `REG_FRAME_ACTIVE: frame_active <= i_wdata[11:0];
        `REG_FRAME_SYNC_WIDTH: frame_sync_width <= i_wdata;
        `REG_FRAME_SYNC_OFFSET: frame_sync_offset <= i_wdata;
        `REG_CLOCK_OFFSET: clock_offset <= i_wdata;
        `REG_VALID_OFFSET: valid_offset <= i_wdata;
        `REG_PIN_MAP: pin_map <= i_wdata[7:0];
        default: ;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads zero
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      case (i_addr)
        `REG_CONTROL: o_rdata <= {{(16-`CTL_WIDTH){1'b0}}, control};
        `REG_COMPONENTS: o_rdata <= {12'h000, components};
        `REG_CLOCK_DIVISOR: o_rdata <= {4'h0, divisor};
        `REG_LINE_TOTAL: o_rdata <= {4'h0, line_total};
        `REG_LINE_LEAD: o_rdata <= {4'h0, line_lead};
        `REG_LINE_ACTIVE: o_rdata <= {4'h0, line_active};
        `REG_LINE_SYNC_WIDTH: o_rdata <= line_sync_width;
        `REG_LINE_SYNC_OFFSET: o_rdata <= line_sync_offset;
        `REG_FRAME_TOTAL: o_rdata <= {4'h0, frame_total};
        `REG_FRAME_LEAD: o_rdata <= {4'h0, frame_lead};
        `REG_FRAME_ACTIVE: o_rdata <= {4'h0, frame_active};
        `REG_FRAME_SYNC_WIDTH: o_rdata <= frame_sync_width;
        `REG_FRAME_SYNC_OFFSET: o_rdata <= frame_sync_offset;
        `REG_CLOCK_OFFSET: o_rdata <= clock_offset;
        `REG_VALID_OFFSET: o_rdata <= valid_offset;
        `REG_PIN_MAP: o_rdata <= {8'h00, pin_map};
        `REG_H_POSITION: o_rdata <= {4'h0, h_pos};
        `REG_V_POSITION: o_rdata <= {4'h0, v_pos};
        default: o_rdata <= 16'h0000;
      endcase
    end else begin
      o_rdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fractional panel clock divider

  wire enable = control[`CTL_ENABLE];
  wire [7:0] div_int = divisor[`DIV_INT_MSB:`DIV_INT_LSB];
  wire [3:0] div_frac = divisor[`DIV_FRAC_MSB:0];
  // Integer part zero is taken as one: a zero period would never end
  wire [7:0] div_floor = (div_int == 8'h00) ? 8'h01 : div_int;

  reg [7:0] per_count;
  reg [8:0] cur_period;
  reg [3:0] frac_acc;
  wire [4:0] acc_sum = {1'b0, frac_acc} + {1'b0, div_frac};
  wire period_end = ({1'b0, per_count} == cur_period - 9'h001);

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      per_count <= 8'h00;
      cur_period <= 9'h001;
      frac_acc <= 4'h0;
    end else if (!enable) begin
      per_count <= 8'h00;
      cur_period <= {1'b0, div_floor};
      frac_acc <= 4'h0;
    end else if (period_end) begin
      per_count <= 8'h00;
      frac_acc <= acc_sum[3:0];
      // Carry stretches the next period by one cycle so the mean is exact
      cur_period <= {1'b0, div_floor} + {8'h00, acc_sum[4]};
    end else begin
      per_count <= per_count + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Horizontal and vertical position

  reg [3:0] comp_count;
  reg active_prev;
  reg [15:0] line_cycles;
  reg [15:0] frame_cycles;

  wire h_last = (h_pos >= line_total - 12'h001);
  wire v_last = (v_pos >= frame_total - 12'h001);
  wire h_active = (h_pos >= line_lead) && (h_pos < line_lead + line_active);
  wire v_active = (v_pos >= frame_lead) && (v_pos < frame_lead + frame_active);
  wire active_now = h_active && v_active;

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      h_pos <= 12'h000;
      v_pos <= 12'h000;
      comp_count <= 4'h0;
      active_prev <= 1'b0;
    end else if (!enable) begin
      h_pos <= 12'h000;
      v_pos <= 12'h000;
      comp_count <= 4'h0;
      active_prev <= 1'b0;
    end else if (period_end) begin
      active_prev <= active_now;
      comp_count <= (comp_count + 4'h1 >= components) ? 4'h0 : comp_count + 4'h1;
      if (h_last) begin
        h_pos <= 12'h000;
        comp_count <= 4'h0;
        v_pos <= v_last ? 12'h000 : v_pos + 12'h001;
      end else begin
        h_pos <= h_pos + 12'h001;
      end
    end
  end

  // Local start counters in base cycles; saturate so long frames hold the sync inactive
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      line_cycles <= 16'hffff;
      frame_cycles <= 16'hffff;
    end else if (!enable) begin
      line_cycles <= 16'hffff;
      frame_cycles <= 16'hffff;
    end else begin
      if (period_end && h_last) begin
        line_cycles <= 16'h0000;
      end else if (line_cycles != 16'hffff) begin
        line_cycles <= line_cycles + 16'h0001;
      end
      if (period_end && h_last && v_last) begin
        frame_cycles <= 16'h0000;
      end else if (frame_cycles != 16'hffff) begin
        frame_cycles <= frame_cycles + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control waveforms on the half-step grid

  // Each counter offers two half positions per base cycle
  wire [16:0] per_half0 = {8'h00, per_count, 1'b0};
  wire [16:0] per_half1 = {8'h00, per_count, 1'b1};
  wire [16:0] line_half0 = {line_cycles, 1'b0};
  wire [16:0] line_half1 = {line_cycles, 1'b1};
  wire [16:0] frame_half0 = {frame_cycles, 1'b0};
  wire [16:0] frame_half1 = {frame_cycles, 1'b1};
  wire [15:0] half_period = {7'h00, cur_period};

  // High phase lasts half the period from the offset; offset past it clips
  wire [1:0] pclk_raw = {in_window(per_half1, clock_offset, half_period),
                         in_window(per_half0, clock_offset, half_period)};
  wire [1:0] lsync_raw = {in_window(line_half1, line_sync_offset, line_sync_width),
    in_window(line_half0, line_sync_offset, line_sync_width)};
  wire [1:0] fsync_raw = {in_window(frame_half1, frame_sync_offset, frame_sync_width),
    in_window(frame_half0, frame_sync_offset, frame_sync_width)};
  // Before the offset the strobe still belongs to the previous data word
  wire valid_h0 = (per_half0 >= {1'b0, valid_offset}) ? active_now : active_prev;
  wire valid_h1 = (per_half1 >= {1'b0, valid_offset}) ? active_now : active_prev;
  wire [1:0] valid_raw = {valid_h1, valid_h0};

  wire [1:0] pclk_pol = enable ? (pclk_raw ^ {2{control[`CTL_CLOCK_INVERT]}}) : 2'b00;
  wire [1:0] lsync_pol = (enable ? lsync_raw : 2'b00) ^ {2{control[`CTL_LINE_SYNC_LOW]}};
  wire [1:0] fsync_pol = (enable ? fsync_raw : 2'b00) ^ {2{control[`CTL_FRAME_SYNC_LOW]}};
  wire [1:0] valid_pol = (enable ? valid_raw : 2'b00) ^ {2{control[`CTL_VALID_LOW]}};
  wire [7:0] ctrl_bus = {valid_pol, fsync_pol, lsync_pol, pclk_pol};

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_pin0 <= 2'b00;
      o_pin1 <= 2'b00;
      o_pin2 <= 2'b00;
      o_pin3 <= 2'b00;
    end else begin
      // Both halves registered together so a pad cell can serialise them
      o_pin0 <= pick(pin_map[1:0], ctrl_bus);
      o_pin1 <= pick(pin_map[3:2], ctrl_bus);
      o_pin2 <= pick(pin_map[5:4], ctrl_bus);
      o_pin3 <= pick(pin_map[7:6], ctrl_bus);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data path

  wire period_start = enable && (per_count == 8'h00);
  wire [11:0] line_end = line_lead + line_active;
  wire in_sav = (h_pos + `CODE_LEN >= line_lead) && (h_pos < line_lead);
  wire in_eav = (h_pos >= line_end) && (h_pos < line_end + `CODE_LEN);
  wire [1:0] sav_index = h_pos[1:0] - line_lead[1:0];
  wire [1:0] eav_index = h_pos[1:0] - line_end[1:0];
  wire [1:0] code_index = in_sav ? sav_index : eav_index;
  wire [7:0] in_data_mapped;
  reg [7:0] next_video;

  genvar bit_i;
  generate
    for (bit_i = 0; bit_i < 8; bit_i = bit_i + 1) begin : g_reverse
      assign in_data_mapped[bit_i] = control[`CTL_DATA_REVERSE] ?
                                     i_video_data[7-bit_i] : i_video_data[bit_i];
    end
  endgenerate

  always @* begin
    next_video = 8'h00;
    if (control[`CTL_LUMA_CHROMA]) begin
      if ((in_sav && (h_pos < line_lead)) || in_eav) begin
        case (code_index)
          2'h0: next_video = `CODE_PREAMBLE_FF;
          2'h1: next_video = `CODE_PREAMBLE_00;
          2'h2: next_video = `CODE_PREAMBLE_00;
          default: next_video = ref_code(!v_active, in_eav);
        endcase
      end else if (active_now) begin
        next_video = in_data_mapped;
      end else begin
        // Blank video only; nothing else may ride in the blanking
        next_video = h_pos[0] ? `BLANK_LUMA : `BLANK_CHROMA;
      end
    end else if (active_now) begin
      next_video = in_data_mapped;
    end
  end

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_video_data <= 8'h00;
      o_data_req <= 1'b0;
    end else begin
      o_data_req <= period_start && active_now;
      if (!enable) begin
        o_video_data <= 8'h00;
      end else if (period_start) begin
        o_video_data <= next_video;
      end
    end
  end

endmodule // panel_sync_timing_generator

`default_nettype wire

/* File: core/panel_timing_consts.vh */
`ifndef PANEL_TIMING_CONSTS_VH
`define PANEL_TIMING_CONSTS_VH

// Register indices on the plain register port
`define REG_CONTROL 5'h00
`define REG_COMPONENTS 5'h01
`define REG_CLOCK_DIVISOR 5'h02
`define REG_LINE_TOTAL 5'h03
`define REG_LINE_LEAD 5'h04
`define REG_LINE_ACTIVE 5'h05
`define REG_LINE_SYNC_WIDTH 5'h06
`define REG_LINE_SYNC_OFFSET 5'h07
`define REG_FRAME_TOTAL 5'h08
`define REG_FRAME_LEAD 5'h09
`define REG_FRAME_ACTIVE 5'h0a
`define REG_FRAME_SYNC_WIDTH 5'h0b
`define REG_FRAME_SYNC_OFFSET 5'h0c
`define REG_CLOCK_OFFSET 5'h0d
`define REG_VALID_OFFSET 5'h0e
`define REG_PIN_MAP 5'h0f
`define REG_H_POSITION 5'h10
`define REG_V_POSITION 5'h11

// Control register bits
`define CTL_ENABLE 0
`define CTL_CLOCK_INVERT 1
`define CTL_LINE_SYNC_LOW 2
`define CTL_FRAME_SYNC_LOW 3
`define CTL_VALID_LOW 4
`define CTL_LUMA_CHROMA 5
`define CTL_DATA_REVERSE 6
`define CTL_WIDTH 7

// Divisor layout: integer part above a four-bit sixteenths field
`define DIV_FRAC_MSB 3
`define DIV_INT_LSB 4
`define DIV_INT_MSB 11

// Reset values
`define RST_CONTROL 7'h00
`define RST_COMPONENTS 4'h1
`define RST_DIVISOR 12'h020
`define RST_PIN_MAP 8'he4

// Control selectors for the pin map
`define SEL_PANEL_CLOCK 2'h0
`define SEL_LINE_SYNC 2'h1
`define SEL_FRAME_SYNC 2'h2
`define SEL_VALID 2'h3

// Embedded reference code bytes, code length and blank levels
`define CODE_PREAMBLE_FF 8'hff
`define CODE_PREAMBLE_00 8'h00
`define CODE_LEN 12'h004
`define BLANK_CHROMA 8'h80
`define BLANK_LUMA 8'h10

`endif

/* File: tb/panel_timing_assertions.sv */
`include "panel_timing_consts.vh"
`default_nettype none
module panel_timing_assertions (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Register port
  input wire logic [4:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  // Pixel and panel side
  input wire logic [7:0] i_video_data,
  input wire logic o_data_req,
  input wire logic [1:0] o_pin0,
  input wire logic [1:0] o_pin1,
  input wire logic [1:0] o_pin2,
  input wire logic [1:0] o_pin3,
  input wire logic [7:0] o_video_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] ctl;
  logic [11:0] div;
  logic [7:0] map;
  logic [2:0] quiet;
  logic [7:0] px_rev;
  logic settled;
  logic [7:0] pins;
  assign settled = quiet > 3'h2;
  assign pins = {o_pin3, o_pin2, o_pin1, o_pin0};
  // Shadows of the mode; quiet gives writes time to reach the pins
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ctl <= `RST_CONTROL;
      div <= `RST_DIVISOR;
      map <= `RST_PIN_MAP;
      quiet <= 3'h0;
      px_rev <= 8'h00;
    end else begin
      quiet <= i_wr ? 3'h0 : (quiet == 3'h7 ? quiet : quiet + 3'h1);
      if (i_wr && i_addr == `REG_CONTROL) ctl <= i_wdata[6:0];
      if (i_wr && i_addr == `REG_CLOCK_DIVISOR) div <= i_wdata[11:0];
      if (i_wr && i_addr == `REG_PIN_MAP) map <= i_wdata[7:0];
      // Mirror image of the offered pixel, for the reversed data mode
      for (int k = 0; k < 8; k++) begin
        px_rev[k] <= i_video_data[7 - k];
      end
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  sequence s_map_wr;
    i_wr && i_addr == `REG_PIN_MAP;
  endsequence
  sequence s_map_rd;
    i_rd && i_addr == `REG_PIN_MAP;
  endsequence
  sequence s_map_rw;
    s_map_wr ##1 s_map_rd;
  endsequence
  // Disabled clock pin stays low even when inverted; syncs and strobe idle high
  sequence s_idle_inv;
    settled && ctl[4:0] == 5'h1e && map == 8'he4;
  endsequence
  sequence s_same_sel;
    settled && map[1:0] == map[3:2];
  endsequence
  sequence s_req_plain;
    o_data_req && ctl[6:5] == 2'b00;
  endsequence
  sequence s_req_rev;
    o_data_req && ctl[6:5] == 2'b10;
  endsequence
  a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not zero outside a read answer");
  a_unmapped_read_zero: assert property (i_rd && i_addr > `REG_V_POSITION |=> o_rdata == 16'h0)
    else $error("unmapped read returned nonzero data");
  a_map_write_read: assert property (s_map_rw |=> o_rdata[7:0] == map)
    else $error("pin map read back differs from write");
  a_idle_pins_low: assert property (settled && ctl[4:0] == 5'h00 |-> pins == 8'h00)
    else $error("disabled pins not low");
  a_idle_pins_inverted: assert property (s_idle_inv |-> pins == 8'hfc)
    else $error("disabled inverted pins wrong");
  a_map_copy_pins: assert property (s_same_sel |-> o_pin0 == o_pin1)
    else $error("pins with one selector differ");
  a_req_when_disabled: assert property (settled && !ctl[0] |-> !o_data_req)
    else $error("data request while disabled");
  a_req_one_cycle: assert property (div[11:4] > 8'h01 && o_data_req |=> !o_data_req)
    else $error("data request longer than one cycle");
  a_video_follows_req: assert property (s_req_plain |-> o_video_data == $past(i_video_data))
    else $error("output data not the sampled pixel");
  a_video_reversed: assert property (s_req_rev |-> o_video_data == px_rev)
    else $error("reversed output data not the mirrored pixel");
endmodule // panel_timing_assertions

bind panel_sync_timing_generator panel_timing_assertions u_panel_timing_assertions (
  .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_video_data(i_video_data), .o_data_req(o_data_req),
  .o_pin0(o_pin0), .o_pin1(o_pin1), .o_pin2(o_pin2), .o_pin3(o_pin3),
  .o_video_data(o_video_data));
`default_nettype wire

/* File: tb/panel_rx_model.sv */
`default_nettype none
module panel_rx_model (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Sync and valid pins, two half phases each; then data request and video byte
  input wire logic [1:0] i_line_sync,
  input wire logic [1:0] i_frame_sync,
  input wire logic [1:0] i_valid,
  input wire logic i_data_req,
  input wire logic [7:0] i_video_data,
  // Pixel source and per-frame figures
  output logic [7:0] o_pixel,
  output logic [10:0][15:0] o_meas
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pl, pf, pv, lr, fr, vr, seen;
  logic [15:0] lcnt, fcnt;
  logic [9:4][15:0] acc, c;
  // A pulse may open in either half of a cycle
  function automatic logic start(input logic [1:0] n, input logic p);
    return (n[0] & ~p) | (n[1] & ~n[0]);
  endfunction
  assign lr = start(i_line_sync, pl);
  assign fr = start(i_frame_sync, pf);
  assign vr = start(i_valid, pv);
  always_comb begin
    c[4] = 16'(i_valid[0]) + 16'(i_valid[1]);
    c[5] = 16'(i_line_sync[0]) + 16'(i_line_sync[1]);
    c[6] = 16'(i_frame_sync[0]) + 16'(i_frame_sync[1]);
    c[7] = 16'(i_data_req);
    c[8] = 16'(i_video_data == 8'hff);
    c[9] = 16'(i_video_data == 8'h00);
  end
  ////////////////////////////////////////
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      {pl, pf, pv, seen} <= 4'h0;
      lcnt <= 16'h0;
      fcnt <= 16'h0;
      acc <= '0;
      o_meas <= '0;
      o_pixel <= 8'h01;
    end else begin
      {pl, pf, pv} <= {i_line_sync[1], i_frame_sync[1], i_valid[1]};
      lcnt <= lr ? 16'h1 : lcnt + 16'h1;
      fcnt <= fr ? 16'h1 : fcnt + 16'h1;
      if (lr) o_meas[0] <= lcnt;
      if (fr) o_meas[1] <= fcnt;
      if (fr) o_meas[10] <= o_meas[10] + 16'h1;
      if (vr) o_meas[2] <= lcnt;
      if (vr && !seen) o_meas[3] <= fcnt;
      seen <= fr ? 1'b0 : (seen | vr);
      for (int k = 4; k <= 9; k++) begin
        if (fr) o_meas[k] <= acc[k];
        acc[k] <= (fr ? 16'h0 : acc[k]) + c[k];
      end
      // Odd values below 8'h80 never look like codes or blank levels
      if (i_data_req) o_pixel <= (o_pixel + 8'h02) & 8'h7f;
    end
  end
endmodule // panel_rx_model
`default_nettype wire

/* File: tb/test_panel_sync_timing_generator.sv */
`include "panel_timing_consts.vh"
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module test_panel_sync_timing_generator;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock, i_rst, i_wr, i_rd, o_data_req;
  logic [4:0] i_addr;
  logic [15:0] i_wdata, o_rdata, v;
  logic [7:0] i_video_data, o_video_data;
  logic [1:0] o_pin0, o_pin1, o_pin2, o_pin3;
  logic [10:0][15:0] meas;
  int n_errors, n_checks;
  panel_sync_timing_generator u_panel_sync_timing_generator (
    .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_video_data(i_video_data), .o_data_req(o_data_req),
    .o_pin0(o_pin0), .o_pin1(o_pin1), .o_pin2(o_pin2), .o_pin3(o_pin3),
    .o_video_data(o_video_data));
  panel_rx_model u_panel_rx_model (
    .i_clock(i_clock), .i_rst(i_rst), .i_line_sync(o_pin1), .i_frame_sync(o_pin2),
    .i_valid(o_pin3), .i_data_req(o_data_req), .i_video_data(o_video_data),
    .o_pixel(i_video_data), .o_meas(meas));
  ////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  // Optional write straight before the read, with no idle cycle between
  task automatic rw(input bit w, input logic [4:0] a, input logic [15:0] d);
    @(posedge i_clock);
    if (w) begin
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clock);
      i_wr <= 1'b0;
    end
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  task automatic rchk(input string nm, input logic [4:0] a, input logic [15:0] e);
    rw(1'b0, a, 16'h0000);
    `CHK(nm, e, v)
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    rchk("control", `REG_CONTROL, 16'h0000);
    rchk("components", `REG_COMPONENTS, 16'h0001);
    rchk("divisor", `REG_CLOCK_DIVISOR, 16'h0020);
    rchk("pin map", `REG_PIN_MAP, 16'h00e4);
    rchk("line total", `REG_LINE_TOTAL, 16'h0000);
    rchk("unmapped", 5'h1f, 16'h0000);
    rw(1'b1, `REG_CLOCK_DIVISOR, 16'hffff);
    `CHK("divisor width", 16'h0fff, v)
    rw(1'b1, `REG_PIN_MAP, 16'h12e4);
    `CHK("pin map width", 16'h00e4, v)
    wr(5'h1f, 16'hffff);
    rchk("control kept", `REG_CONTROL, 16'h0000);
    wr(`REG_CLOCK_DIVISOR, 16'h0020);
    $display("done register map");
  endtask
  task automatic t_idle();
    wr(`REG_CONTROL, 16'h001e);
    repeat (4) @(posedge i_clock);
    #1;
    // Clock pin is held low while disabled, whatever its polarity
    `CHK("inverted idle pins", 8'hfc, {o_pin3, o_pin2, o_pin1, o_pin0})
    wr(`REG_CONTROL, 16'h0000);
    repeat (4) @(posedge i_clock);
    #1;
    `CHK("plain idle pins", 8'h00, {o_pin3, o_pin2, o_pin1, o_pin0})
    $display("done idle polarity");
  endtask
  // Five lines of ten or twelve panel clocks, two active lines of four
  task automatic t_frame(input string nm, input logic [15:0] ctl, input logic [15:0] dv,
    input int lt, input int lead, input int lp, input int ld, input int vh, input int ff,
    input int zero);
    logic [15:0] start;
    int i;
    wr(`REG_CONTROL, 16'h0000);
    wr(`REG_CLOCK_DIVISOR, dv);
    wr(`REG_LINE_TOTAL, 16'(lt));
    wr(`REG_LINE_LEAD, 16'(lead));
    wr(`REG_LINE_ACTIVE, 16'h0004);
    wr(`REG_LINE_SYNC_WIDTH, 16'h0003);
    wr(`REG_FRAME_TOTAL, 16'h0005);
    wr(`REG_FRAME_LEAD, 16'h0001);
    wr(`REG_FRAME_ACTIVE, 16'h0002);
    wr(`REG_FRAME_SYNC_WIDTH, 16'h0005);
    wr(`REG_CONTROL, ctl);
    start = meas[10];
    for (i = 0; i < 3000 && meas[10] - start < 16'h3; i++) begin
      @(posedge i_clock);
      #1;
    end
    if (meas[10] - start < 16'h3) begin
      `CHK("frame wait", 16'h3, meas[10] - start)
      summarize();
    end
    `CHK("line period", lp, meas[0])
    `CHK("frame period", 5 * lp, meas[1])
    `CHK("line lead", ld, meas[2])
    `CHK("frame lead", lp + ld, meas[3])
    `CHK("valid halves", vh, meas[4])
    `CHK("line sync halves", 15, meas[5])
    `CHK("frame sync halves", 5, meas[6])
    `CHK("requests", 8, meas[7])
    `CHK("code bytes", ff, meas[8])
    `CHK("blank cycles", zero, meas[9])
    $display("done %s", nm);
  endtask
  task automatic t_pin_map();
    int bad = 0;
    int halves = 0;
    wr(`REG_PIN_MAP, 16'h00e5);
    repeat (3) @(posedge i_clock);
    // Five whole line periods, so any starting phase gives the same sum
    for (int i = 0; i < 100; i++) begin
      @(posedge i_clock);
      #1;
      bad += (o_pin0 !== o_pin1);
      halves += (o_pin0[0] === 1'b1) + (o_pin0[1] === 1'b1);
    end
    `CHK("pins matching", 0, bad)
    `CHK("line sync on pin0", 15, halves)
    wr(`REG_PIN_MAP, 16'h00e4);
    $display("done pin map");
  endtask
  ////////////////////////////////////////
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  initial begin
    {i_rst, i_wr, i_rd} = 3'b100;
    i_addr = 5'h00;
    i_wdata = 16'h0000;
    n_errors = 0;
    n_checks = 0;
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    t_regs();
    t_idle();
    t_frame("rgb whole", 16'h0001, 16'h0020, 10, 2, 20, 4, 32, 0, 84);
    t_pin_map();
    // Mirrored pixels never read as all ones or all zeros, so the counts stay
    t_frame("rgb reversed", 16'h0041, 16'h0020, 10, 2, 20, 4, 32, 0, 84);
    t_frame("rgb fraction", 16'h0001, 16'h0028, 10, 2, 25, 5, 40, 0, 105);
    t_frame("luma chroma", 16'h0021, 16'h0020, 12, 4, 24, 8, 32, 20, 40);
    summarize();
  end
endmodule // test_panel_sync_timing_generator
`default_nettype wire
